// *** core/pbsp_pkg.sv ***
package pbsp_pkg;

	// geometry of the memory and its pins
	localparam int ADDR_W = 20;
	localparam int LANES = 4;
	localparam int BYTE_W = 8;
	localparam int DATA_W = LANES * BYTE_W;
	localparam int FIFO_DEPTH = 8;

	// clock and sleep timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SLEEP_ENTRY_TCYC = 2; // longest entry time, in clock periods
	localparam int SLEEP_RECOVERY_TCYC = 2; // least recovery time
	localparam int SLEEP_ENTRY_NS = SLEEP_ENTRY_TCYC * CLK_PERIOD_NS;
	localparam int SLEEP_RECOVERY_NS = SLEEP_RECOVERY_TCYC * CLK_PERIOD_NS;
	// longest time rounds down, least time rounds up
	localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_NS / CLK_PERIOD_NS;
	localparam int SLEEP_RECOVERY_CYC =
		(SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// values after reset and fixed codes
	localparam logic [LANES-1:0] LANES_NONE = 4'hF;
	localparam logic [1:0] BURST_START = 2'h0;
	localparam logic [1:0] BURST_STEP = 2'h1;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
	localparam logic BURST_LINEAR = 1'h0;

	// one bus word: data bytes plus one parity bit per lane
	typedef struct packed {
		logic [LANES-1:0] parity;
		logic [DATA_W-1:0] data;
	} pbsp_word_t;

	localparam pbsp_word_t WORD_RESET = '0;

	// kind of access in flight
	typedef enum logic [1:0] {
		OP_IDLE,
		OP_READ,
		OP_WRITE
	} pbsp_op_t;

	// one access cycle travelling through the pipeline
	typedef struct packed {
		pbsp_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lanes_n;
	} pbsp_cyc_t;

	// one write waiting to reach the array
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lanes_n;
		pbsp_word_t word;
	} pbsp_wr_t;

	localparam pbsp_cyc_t CYC_IDLE = '{op: OP_IDLE, addr: ADDR_RESET,
		lanes_n: LANES_NONE};

	// low address bits of the burst access number cnt
	function automatic logic [1:0] pbsp_burst_low(input logic [1:0] start,
		input logic [1:0] cnt, input logic interleave);
		logic [1:0] sum;
		sum = 2'(start + cnt);
		return interleave ? (start ^ cnt) : sum;
	endfunction

endpackage

// *** core/pbsp_fifo.sv ***
`timescale 1ns/1ns
module pbsp_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic en, // clock enable, freezes state when low
	input wire logic in_valid, // a word is offered
	output logic in_ready, // room for a word, registered
	input wire logic [W-1:0] in_data, // word offered
	output logic out_valid, // a word is waiting
	input wire logic out_ready, // drain side takes the word
	output logic [W-1:0] out_data // oldest word
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [W-1:0] store_q [DEPTH];
	logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [CW-1:0] count_q, count_d;
	logic ready_q, ready_d;
	logic push, pop;

	// handshakes on both sides
	assign push = in_valid & ready_q;
	assign pop = out_valid & out_ready;
	assign in_ready = ready_q;
	assign out_valid = (count_q != '0);
	assign out_data = store_q[rd_ptr_q];

	// pointer and fill level next values
	always_comb begin
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d = count_q;
		if (push) begin
			wr_ptr_d = (wr_ptr_q == LAST) ? '0 : PW'(wr_ptr_q + 1'b1);
		end
		if (pop) begin
			rd_ptr_d = (rd_ptr_q == LAST) ? '0 : PW'(rd_ptr_q + 1'b1);
		end
		if (push && !pop) begin
			count_d = CW'(count_q + 1'b1);
		end else if (pop && !push) begin
			count_d = CW'(count_q - 1'b1);
		end
		ready_d = (count_d != FULL);
	end

	// register pointers, level and ready
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			ready_q <= 1'b1;
		end else if (en) begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
			ready_q <= ready_d;
		end
	end

	// word storage
	always_ff @(posedge clk) begin
		if (en && push) begin
			store_q[wr_ptr_q] <= in_data;
		end
	end
endmodule

// *** core/pbsp_top.sv ***
`timescale 1ns/1ns
module pbsp_top
	import pbsp_pkg::*;
(
	input wire logic CLK, // system clock
	input wire logic RST, // synchronous reset, high
	input wire logic CLK_EN, // clock enable, freezes all state when low
	input wire logic [ADDR_W-1:0] ADDR, // external address
	input wire logic CHIP_SELECT_ONE_N, // chip select, low active
	input wire logic CHIP_SELECT_TWO, // chip select, high active
	input wire logic CHIP_SELECT_THREE_N, // chip select, low active
	input wire logic ADVANCE_OR_LOAD_N, // high advances, low loads
	input wire logic WRITE_STROBE_N, // low marks a write
	input wire logic [LANES-1:0] BYTE_LANE_WRITE_N, // lane write selects
	input wire logic CLOCK_QUALIFIER_N, // high ignores the edge
	input wire logic SLEEP_REQUEST, // asynchronous sleep request
	input wire logic OUTPUT_ENABLE_N, // asynchronous output enable
	input wire logic BURST_ORDER, // high selects interleaved order
	input wire pbsp_word_t BUS_IN, // data and parity from the wire
	output pbsp_word_t BUS_OUT, // read data and parity
	output logic BUS_OE, // high while driving the bus
	output logic ASLEEP, // sleep in effect
	output logic WRITE_READY // write buffer has room
);
	logic sleep_meta_q, sleep_meta_d;
	logic sleep_q, sleep_d;
	pbsp_op_t op_q, op_d;
	logic [ADDR_W-1:0] base_q, base_d;
	logic [1:0] cnt_q, cnt_d;
	logic mode_q, mode_d;
	pbsp_cyc_t cyc1_q, cyc1_d;
	pbsp_cyc_t cyc2_q, cyc2_d;
	logic drive_q, drive_d;
	pbsp_word_t rd_word_q, rd_word_d;
	pbsp_word_t mem_q [2**ADDR_W];
	pbsp_wr_t push_data, drain_data;
	logic push_valid, push_ready;
	logic drain_valid, drain_ready;
	logic qual, selected, load;
	logic [1:0] next_low;

	// true when a lane select pattern writes at least one byte
	function automatic logic pbsp_lanes_any(input logic [LANES-1:0] lanes_n);
		return lanes_n != LANES_NONE;
	endfunction

	// sleep request crosses in through two flip-flops
	always_comb begin
		sleep_meta_d = SLEEP_REQUEST;
		sleep_d = sleep_meta_q;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			sleep_meta_q <= 1'b0;
			sleep_q <= 1'b0;
		end else if (CLK_EN) begin
			sleep_meta_q <= sleep_meta_d;
			sleep_q <= sleep_d;
		end
	end

	// decode of the pins at this edge
	assign qual = !CLOCK_QUALIFIER_N && !sleep_q;
	assign selected = !CHIP_SELECT_ONE_N && CHIP_SELECT_TWO &&
		!CHIP_SELECT_THREE_N;
	assign load = !ADVANCE_OR_LOAD_N;
	assign next_low = pbsp_burst_low(base_q[1:0], 2'(cnt_q + BURST_STEP),
		mode_q);

	// burst state: kind of access, start address, count, order
	always_comb begin
		op_d = op_q;
		base_d = base_q;
		cnt_d = cnt_q;
		mode_d = mode_q;
		if (sleep_q) begin
			op_d = OP_IDLE;
		end else if (qual) begin
			if (load) begin
				cnt_d = BURST_START;
				if (selected) begin
					// strobe alone decides read or write
					op_d = WRITE_STROBE_N ? OP_READ : OP_WRITE;
					base_d = ADDR;
					mode_d = BURST_ORDER;
				end else begin
					op_d = OP_IDLE;
				end
			end else if (op_q != OP_IDLE) begin
				cnt_d = 2'(cnt_q + BURST_STEP);
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			op_q <= OP_IDLE;
			base_q <= ADDR_RESET;
			cnt_q <= BURST_START;
			mode_q <= BURST_LINEAR;
		end else if (CLK_EN) begin
			op_q <= op_d;
			base_q <= base_d;
			cnt_q <= cnt_d;
			mode_q <= mode_d;
		end
	end

	// pipeline: the access of this cycle, then the pending write data
	always_comb begin
		cyc1_d = cyc1_q;
		cyc2_d = cyc2_q;
		if (sleep_q) begin
			cyc1_d = CYC_IDLE;
			cyc2_d = CYC_IDLE;
		end else if (qual) begin
			if (load) begin
				cyc1_d = CYC_IDLE;
				if (selected) begin
					cyc1_d.op = WRITE_STROBE_N ? OP_READ : OP_WRITE;
					cyc1_d.addr = ADDR;
					// an all-high pattern is a write abort
					cyc1_d.lanes_n = WRITE_STROBE_N ? LANES_NONE :
						BYTE_LANE_WRITE_N;
				end
			end else begin
				// chip selects and strobe are ignored while advancing
				cyc1_d.op = op_q;
				cyc1_d.addr = {base_q[ADDR_W-1:2], next_low};
				cyc1_d.lanes_n = (op_q == OP_WRITE) ? BYTE_LANE_WRITE_N :
					LANES_NONE;
			end
			cyc2_d = (cyc1_q.op == OP_WRITE) ? cyc1_q : CYC_IDLE;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			cyc1_q <= CYC_IDLE;
			cyc2_q <= CYC_IDLE;
		end else if (CLK_EN) begin
			cyc1_q <= cyc1_d;
			cyc2_q <= cyc2_d;
		end
	end

	// output register: read data one qualified edge after the address
	always_comb begin
		drive_d = drive_q;
		rd_word_d = rd_word_q;
		if (sleep_q) begin
			drive_d = 1'b0;
		end else if (qual) begin
			// writes and deselects leave the drivers off
			drive_d = (cyc1_q.op == OP_READ);
			if (cyc1_q.op == OP_READ) begin
				rd_word_d = mem_q[cyc1_q.addr];
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			drive_q <= 1'b0;
			rd_word_q <= WORD_RESET;
		end else if (CLK_EN) begin
			drive_q <= drive_d;
			rd_word_q <= rd_word_d;
		end
	end

	// bus pins: output enable gates the drivers without a clock
	assign BUS_OUT = rd_word_q;
	assign BUS_OE = drive_q && !OUTPUT_ENABLE_N;
	assign ASLEEP = sleep_q;
	assign WRITE_READY = push_ready;

	// capture write data at the second qualified edge
	assign push_valid = qual && (cyc2_q.op == OP_WRITE) &&
		pbsp_lanes_any(cyc2_q.lanes_n);
	assign push_data = '{addr: cyc2_q.addr, lanes_n: cyc2_q.lanes_n,
		word: BUS_IN};
	// the array does not accept writes while asleep
	assign drain_ready = !sleep_q;

	pbsp_fifo #(
		.W($bits(pbsp_wr_t)),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clk(CLK),
		.rst(RST),
		.en(CLK_EN),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(drain_valid),
		.out_ready(drain_ready),
		.out_data(drain_data)
	);

	// array write, one lane of data and parity per select
	always_ff @(posedge CLK) begin
		if (CLK_EN && drain_valid && drain_ready) begin
			for (int i = 0; i < LANES; i++) begin
				if (!drain_data.lanes_n[i]) begin
					mem_q[drain_data.addr].data[i*BYTE_W +: BYTE_W] <=
						drain_data.word.data[i*BYTE_W +: BYTE_W];
					mem_q[drain_data.addr].parity[i] <=
						drain_data.word.parity[i];
				end
			end
		end
	end
endmodule

// *** verif/pbsp_chk.sv ***
`timescale 1ns/1ns
module pbsp_chk
	import pbsp_pkg::*;
(
	input wire logic CLK, // clock
	input wire logic RST, // reset
	input wire logic CLK_EN, // clock enable
	input wire logic CHIP_SELECT_ONE_N, // select
	input wire logic CHIP_SELECT_TWO, // select
	input wire logic CHIP_SELECT_THREE_N, // select
	input wire logic ADVANCE_OR_LOAD_N, // advance or load
	input wire logic WRITE_STROBE_N, // write strobe
	input wire logic CLOCK_QUALIFIER_N, // edge qualifier
	input wire logic SLEEP_REQUEST, // sleep request
	input wire logic OUTPUT_ENABLE_N, // output enable
	input wire pbsp_word_t BUS_OUT, // read word
	input wire logic BUS_OE, // drive enable
	input wire logic ASLEEP // sleep in effect
);
	logic q, ld, sel;
	// edge taken by the device, load edge and full select
	assign q = CLK_EN && !CLOCK_QUALIFIER_N && !ASLEEP;
	assign ld = q && !ADVANCE_OR_LOAD_N;
	assign sel = !CHIP_SELECT_ONE_N && CHIP_SELECT_TWO &&
		!CHIP_SELECT_THREE_N;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	AST_OE_OFF: assert property (OUTPUT_ENABLE_N |-> !BUS_OE)
		else $error("drive without output enable");
	AST_SLEEP_OFF: assert property (ASLEEP |-> !BUS_OE)
		else $error("drive while asleep");
	AST_SLEEP_IN: assert property (
		(SLEEP_REQUEST && CLK_EN) [*2] |=> ASLEEP)
		else $error("sleep entry late");
	AST_WR_TRI: assert property (ld && sel && !WRITE_STROBE_N ##1 q |=> !BUS_OE)
		else $error("drive after write");
	AST_DESEL: assert property (ld && !sel ##1 q |=> !BUS_OE)
		else $error("drive after deselect");
	AST_RD_ON: assert property (ld && sel && WRITE_STROBE_N ##1 q |=>
		BUS_OE || OUTPUT_ENABLE_N || ASLEEP) else $error("read not driven");
	AST_STALL: assert property ((!CLK_EN || CLOCK_QUALIFIER_N) && !ASLEEP
		|=> $stable(BUS_OUT) || ASLEEP) else $error("stall moved data");
	AST_KEEP: assert property (ld && !sel ##1 q && ADVANCE_OR_LOAD_N ##1 q
		|=> !BUS_OE) else $error("advance left deselect");
endmodule

// *** verif/pbsp_ctl_model.sv ***
`timescale 1ns/1ns
module pbsp_ctl_model
	import pbsp_pkg::*;
(
	input wire logic clk, // clock
	input wire logic drive, // write data cycle
	input wire pbsp_word_t word, // write data and parity
	output pbsp_word_t bus_in // wire seen by device
);
	pbsp_word_t noise_q = WORD_RESET;
	// a released wire shows a pattern that flips every cycle
	always_ff @(posedge clk) begin
		noise_q <= ~noise_q;
	end
	// data only in the write data cycle, never over read data
	assign bus_in = drive ? word : noise_q;
endmodule

// *** verif/pbsp_top_tb.sv ***
`timescale 1ns/1ns
module pbsp_top_tb;
	import pbsp_pkg::*;
	logic clk = 1'h0, rst = 1'h1, adv_n = 1'h1, we_n = 1'h1, sel_n = 1'h1;
	logic qual_n = 1'h0, sleep = 1'h0, oe_n = 1'h0, order = 1'h0, drv = 1'h0;
	logic [ADDR_W-1:0] addr = ADDR_RESET;
	logic [LANES-1:0] bw_n = LANES_NONE;
	logic bus_oe, asleep, wr_rdy;
	logic [7:0] seq = 8'h00;
	pbsp_word_t wd = WORD_RESET, bus_in, bus_out;
	pbsp_word_t mem [logic [ADDR_W-1:0]];
	int num_errors = 0, total_checks = 0, cycles = 0;
	pbsp_top i_pbsp_top (.CLK(clk), .RST(rst), .CLK_EN(1'h1), .ADDR(addr),
		.CHIP_SELECT_ONE_N(sel_n), .CHIP_SELECT_TWO(1'h1),
		.CHIP_SELECT_THREE_N(1'h0), .ADVANCE_OR_LOAD_N(adv_n),
		.WRITE_STROBE_N(we_n), .BYTE_LANE_WRITE_N(bw_n),
		.CLOCK_QUALIFIER_N(qual_n), .SLEEP_REQUEST(sleep),
		.OUTPUT_ENABLE_N(oe_n), .BURST_ORDER(order), .BUS_IN(bus_in),
		.BUS_OUT(bus_out), .BUS_OE(bus_oe), .ASLEEP(asleep),
		.WRITE_READY(wr_rdy));
	pbsp_ctl_model i_pbsp_ctl_model (.clk(clk), .drive(drv), .word(wd),
		.bus_in(bus_in));
	// clock and hang guard
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 600) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic chk(input logic [35:0] s, e, input string nm);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// address of access k in linear or interleaved order
	function automatic logic [ADDR_W-1:0] baddr(input logic [ADDR_W-1:0] a,
		input int k, input logic il);
		logic [1:0] n;
		n = 2'(k);
		return {a[ADDR_W-1:2], (il ? (a[1:0] ^ n) : 2'(a[1:0] + n))};
	endfunction
	// load, three advances, deselect, continued deselect; oe bit k = oe_n for access k
	task automatic burst(input logic wr, il, input logic [ADDR_W-1:0] a,
		input logic [15:0] bw, input logic [3:0] oe, input int st);
		logic [ADDR_W-1:0] ak;
		pbsp_word_t w;
		seq++;
		for (int i = 0; i < 8; i++) begin
			if (i == st) begin
				@(posedge clk);
				qual_n <= 1'h1;
			end
			@(posedge clk);
			ak = baddr(a, i - 2, il);
			w = {ak[3:0] ^ seq[3:0], seq, 4'h0, ak};
			qual_n <= 1'h0;
			adv_n <= (i inside {[1:3]}) || i > 4;
			sel_n <= i > 3;
			we_n <= !wr;
			order <= il;
			addr <= a;
			bw_n <= i < 4 ? bw[4*i+:4] : LANES_NONE;
			drv <= wr && (i inside {[2:5]});
			oe_n <= oe[(i+2)%4];
			if (wr && (i inside {[2:5]})) begin
				wd <= w;
				for (int l = 0; l < LANES; l++) begin
					if (!bw[4*(i-2)+l]) begin
						mem[ak].data[8*l+:8] = w.data[8*l+:8];
						mem[ak].parity[l] = w.parity[l];
					end
				end
			end
			#1;
			if (i inside {[2:5]}) begin
				chk(36'(bus_oe), 36'(!wr && !oe[i-2]), "drive");
				if (!wr && !oe[i-2]) chk(bus_out, mem[ak], "read");
			end
			if (i == 7) chk(36'(bus_oe), 36'h0, "deselect");
		end
	endtask
	task automatic t_reset();
		chk(bus_out, WORD_RESET, "reset word");
		chk(36'(bus_oe), 36'h0, "reset drive");
		chk(36'(wr_rdy), 36'h1, "reset room");
		$display("test reset done");
	endtask
	task automatic t_linear();
		burst(1'h1, 1'h0, 20'h00101, 16'h0000, 4'h0, 9);
		burst(1'h0, 1'h0, 20'h00101, 16'h0000, 4'h0, 9);
		$display("test linear done");
	endtask
	task automatic t_lanes();
		burst(1'h1, 1'h1, 20'h00201, 16'h0000, 4'h0, 9);
		burst(1'h0, 1'h1, 20'h00203, 16'hFFFF, 4'h0, 9);
		burst(1'h1, 1'h0, 20'h00200, 16'h0F5A, 4'h0, 9);
		burst(1'h0, 1'h0, 20'h00200, 16'h0000, 4'h0, 9);
		$display("test lanes done");
	endtask
	task automatic t_abort();
		burst(1'h1, 1'h0, 20'h00300, 16'h000F, 4'h0, 9);
		burst(1'h0, 1'h0, 20'h00300, 16'h0000, 4'h3, 3);
		$display("test abort done");
	endtask
	task automatic t_sleep();
		@(posedge clk);
		sleep <= 1'h1;
		oe_n <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
		chk(36'(asleep), 36'h1, "asleep");
		chk(36'(bus_oe), 36'h0, "sleep drive");
		@(posedge clk);
		sleep <= 1'h0;
		repeat (4) @(posedge clk);
		#1;
		chk(36'(asleep), 36'h0, "awake");
		burst(1'h0, 1'h0, 20'h00301, 16'h0000, 4'h8, 9);
		$display("test sleep done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		#1;
		t_reset();
		t_linear();
		t_lanes();
		t_abort();
		t_sleep();
		stop_test();
	end
endmodule
bind pbsp_top pbsp_chk i_pbsp_chk (.CLK, .RST, .CLK_EN, .CHIP_SELECT_ONE_N,
	.CHIP_SELECT_TWO, .CHIP_SELECT_THREE_N, .ADVANCE_OR_LOAD_N,
	.WRITE_STROBE_N, .CLOCK_QUALIFIER_N, .SLEEP_REQUEST, .OUTPUT_ENABLE_N,
	.BUS_OUT, .BUS_OE, .ASLEEP);
